// ### pkg/ttt_cfg.svh
// Constants of the test timeout timer
`ifndef TTT_CFG_SVH
`define TTT_CFG_SVH
`define TTT_DUR_MIN 7'h01
`define TTT_DUR_MAX 7'h78
`define TTT_DUR_RST 7'h0A
`define TTT_CLK_HZ 10000000
`define TTT_MINUTE_S 60
`define TTT_MINUTE_CYC (`TTT_CLK_HZ * `TTT_MINUTE_S)
`define TTT_DIG_ONES 2'h0
`define TTT_DIG_TENS 2'h1
`define TTT_DIG_HUNS 2'h2
`endif

// ### pkg/ttt_pkg.sv
// Types of the test timeout timer
package ttt_pkg;
  typedef enum logic [2:0] {
    TTT_IDLE = 3'b001,
    TTT_TIMED = 3'b010,
    TTT_MANUAL = 3'b100
  } ttt_state_type;
  typedef logic [1:0] ttt_digit_type;
endpackage

// ### logic/ttt_tick.sv
// Minute tick generator
`timescale 1ns/1ps
`default_nettype none
module ttt_tick #(
  parameter int unsigned CYCLES = 600000000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_q >= CYCLES - 1) begin
      cnt_q <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### logic/ttt_timer.sv
// Test timeout supervisor with duration editor
// Overview of operation
// RQ1: Timeout on: tests end after duration
// RQ2: Timeout off: only manual stop ends test
// RQ3: Duration is 1 to 120 minutes
// RQ4: Duration used only when timeout on
// RQ5: Cursor commands select edited digit
// RQ6: Increment raises selected digit by one
// RQ7: Decrement lowers selected digit by one
// RQ8: Store commits pending value; else unchanged
// RQ9: Remote units should enable timeout; the timer has no remote units and takes timeout only from the timeout_en input
// RQ10: Minute counter loaded, decremented, ends test
// RQ11: Pending value clamped to 1..120
`include "ttt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ttt_timer import ttt_pkg::*; #(
  parameter int unsigned MINUTE_CYC = `TTT_MINUTE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic timeout_en,
  input wire logic test_start,
  input wire logic manual_stop,
  input wire logic cur_left,
  input wire logic cur_right,
  input wire logic dig_up,
  input wire logic dig_down,
  input wire logic store,
  output logic test_active,
  output logic test_end,
  output logic [6:0] active_dur,
  output logic [6:0] pending_dur,
  output logic [1:0] cursor,
  output logic [6:0] minutes_left
);
  ttt_state_type state_q;
  logic tick;
  logic [6:0] edit_v;

  function automatic logic [6:0] digit_step(input logic [6:0] v, input logic [1:0] d,
                                            input logic up);
    logic [8:0] w;
    logic [8:0] s;
    logic [8:0] r;
    w = {2'h0, v};
    s = (d == `TTT_DIG_ONES) ? 9'h001 : (d == `TTT_DIG_TENS) ? 9'h00A : 9'h064;
    r = up ? w + s : ((w > s) ? w - s : 9'h000);
    if (r < {2'h0, `TTT_DUR_MIN}) begin
      r = {2'h0, `TTT_DUR_MIN}; // [RQ11]
    end else if (r > {2'h0, `TTT_DUR_MAX}) begin
      r = {2'h0, `TTT_DUR_MAX}; // [RQ11]
    end
    return r[6:0];
  endfunction

  ttt_tick #(.CYCLES(MINUTE_CYC)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  always_comb begin
    edit_v = pending_dur;
    if (dig_up) begin
      edit_v = digit_step(pending_dur, cursor, 1'b1); // [RQ6] [RQ3]
    end else if (dig_down) begin
      edit_v = digit_step(pending_dur, cursor, 1'b0); // [RQ7] [RQ3]
    end
  end

  // Cursor selects ones, tens or hundreds digit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cursor <= `TTT_DIG_ONES;
    end else if (cur_left && cursor != `TTT_DIG_HUNS) begin
      cursor <= cursor + 2'h1; // [RQ5]
    end else if (cur_right && cursor != `TTT_DIG_ONES) begin
      cursor <= cursor - 2'h1; // [RQ5]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_dur <= `TTT_DUR_RST;
    end else begin
      pending_dur <= edit_v;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_dur <= `TTT_DUR_RST;
    end else if (store) begin
      active_dur <= edit_v; // [RQ8]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= TTT_IDLE;
      minutes_left <= 7'h00;
      test_end <= 1'b0;
    end else begin
      test_end <= 1'b0;
      case (state_q)
        TTT_IDLE: begin
          if (test_start && timeout_en) begin
            state_q <= TTT_TIMED; // [RQ1] [RQ4]
            minutes_left <= active_dur; // [RQ10]
          end else if (test_start) begin
            state_q <= TTT_MANUAL; // [RQ2] [RQ4]
          end
        end
        TTT_TIMED: begin
          if (manual_stop) begin
            state_q <= TTT_IDLE;
            test_end <= 1'b1;
          end else if (tick) begin
            minutes_left <= minutes_left - 7'h01; // [RQ10]
            if (minutes_left == 7'h01) begin
              state_q <= TTT_IDLE; // [RQ1]
              test_end <= 1'b1; // [RQ10]
            end
          end
        end
        TTT_MANUAL: begin
          if (manual_stop) begin
            state_q <= TTT_IDLE; // [RQ2]
            test_end <= 1'b1;
          end
        end
        default: state_q <= TTT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_active <= 1'b0;
    end else begin
      test_active <= (state_q != TTT_IDLE);
    end
  end

  sequence manual_run_s;
    state_q == TTT_MANUAL && !manual_stop;
  endsequence

  manual_no_end_a: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    manual_run_s |=> !test_end) else $error("manual test ended itself");
  timed_end_a: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    (state_q == TTT_TIMED && tick && minutes_left == 7'h01 && !manual_stop) |=> test_end)
    else $error("timed test missed its end");
  timed_load_a: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    (state_q == TTT_IDLE && test_start && timeout_en) |=> minutes_left == $past(active_dur))
    else $error("minute counter not loaded");
  enable_off_a: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    (state_q == TTT_IDLE && test_start && !timeout_en) |=> state_q == TTT_MANUAL)
    else $error("untimed start not manual");
  range_held_a: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    pending_dur >= `TTT_DUR_MIN && pending_dur <= `TTT_DUR_MAX)
    else $error("pending out of range");
  store_commit_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    store |=> active_dur == pending_dur) else $error("store not committed");
  no_store_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    !store |=> $stable(active_dur)) else $error("active changed without store");
  up_ones_a: assert property (@(posedge clk) disable iff (rst) // [RQ6]
    (dig_up && cursor == `TTT_DIG_ONES && pending_dur < `TTT_DUR_MAX)
    |=> pending_dur == $past(pending_dur) + 7'h01) else $error("increment wrong");
  down_tens_a: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    (!dig_up && dig_down && cursor == `TTT_DIG_TENS && pending_dur > 7'h0B)
    |=> pending_dur == $past(pending_dur) - 7'h0A) else $error("decrement wrong");
  cursor_move_a: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    (cur_left && cursor == `TTT_DIG_ONES) |=> cursor == `TTT_DIG_TENS)
    else $error("cursor did not move");
  clamp_top_a: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    (dig_up && cursor == `TTT_DIG_HUNS && pending_dur > 7'h14) |=> pending_dur == `TTT_DUR_MAX)
    else $error("clamp failed");

  // Countdown steps, end pulse shape, active flag, idle and edit holds, cursor right move
  sequence timed_tick_s;
    state_q == TTT_TIMED && tick && !manual_stop;
  endsequence

  count_down_a: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    timed_tick_s |=> minutes_left == $past(minutes_left) - 7'h01)
    else $error("countdown step wrong");
  end_pulse_a: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    test_end |=> !test_end)
    else $error("end pulse too long");
  active_follow_a: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    (state_q != TTT_IDLE) |=> test_active)
    else $error("active flag missing");
  idle_hold_a: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    (state_q == TTT_IDLE && !test_start) |=> state_q == TTT_IDLE)
    else $error("test started by itself");
  edit_hold_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    (!dig_up && !dig_down) |=> $stable(pending_dur))
    else $error("pending changed without edit");
  cursor_right_a: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    (cur_right && !cur_left && cursor == `TTT_DIG_TENS) |=> cursor == `TTT_DIG_ONES)
    else $error("cursor did not move right");
endmodule
`default_nettype wire

// ### test/ttt_engine.sv
// Behavioural test engine under supervision
`timescale 1ns/1ps
`default_nettype none
module ttt_engine (
  input wire logic clk,
  input wire logic rst,
  input wire logic test_active,
  input wire logic test_end,
  output logic engine_on
);
  // Runs while supervised, stops on terminate pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      engine_on <= 1'h0;
    end else begin
      engine_on <= test_active & ~test_end;
    end
  end
endmodule
`default_nettype wire

// ### test/tb_test_timeout_timer.sv
// Testbench of the test timeout timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("Error %s exp %0h got %0h", s, e, g); end end
module tb_test_timeout_timer import ttt_pkg::*;;
  logic clk = 0, rst = 1, timeout_en = 0, test_start = 0, manual_stop = 0;
  logic cur_left = 0, cur_right = 0, dig_up = 0, dig_down = 0, store = 0;
  logic test_active, test_end, engine_on;
  logic [6:0] active_dur, pending_dur, minutes_left;
  logic [1:0] cursor;
  logic [8:0] q[$];
  logic [8:0] e;
  int errors = 0, samples_checked = 0, n;
  always #50 clk = ~clk;
  ttt_timer #(.MINUTE_CYC(20)) DUT (.clk, .rst, .timeout_en, .test_start, .manual_stop,
    .cur_left, .cur_right, .dig_up, .dig_down, .store, .test_active, .test_end,
    .active_dur, .pending_dur, .cursor, .minutes_left);
  ttt_engine eng (.clk, .rst, .test_active, .test_end, .engine_on);
  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(posedge clk) #1 s = 0;
    @(posedge clk) #1;
  endtask
  task automatic expect_val(input logic [1:0] k, input logic [6:0] v);
    q.push_back({k, v});
    @(posedge clk) #1;
  endtask
  task automatic wait_end(input int lim);
    n = 0;
    while (test_end !== 1'h1) begin
      @(posedge clk) #1;
      n++;
      if (n > lim) begin
        errors++;
        give_verdict();
      end
    end
  endtask
  always @(negedge clk) while (q.size() > 0) begin
    e = q.pop_front();
    case (e[8:7])
      2'h0: `CHK("pending_dur", e[6:0], pending_dur)
      2'h1: `CHK("active_dur", e[6:0], active_dur)
      2'h2: `CHK("cursor", e[1:0], cursor)
      default: `CHK("test_active", e[0], test_active)
    endcase
  end
  initial begin
    void'($urandom(30522));
    repeat (12) @(posedge clk);
    #1 rst = 0;
    expect_val(0, 7'h0A);
    expect_val(1, 7'h0A);
    repeat ($urandom % 4 + 2) pulse(cur_left);
    expect_val(2, 7'h02);
    pulse(dig_up);
    expect_val(0, 7'h6E);
    pulse(dig_up);
    expect_val(0, 7'h78);
    expect_val(1, 7'h0A);
    pulse(store);
    expect_val(1, 7'h78);
    pulse(dig_down);
    expect_val(0, 7'h14);
    pulse(cur_right);
    pulse(dig_down);
    pulse(dig_down);
    expect_val(0, 7'h01);
    pulse(cur_right);
    expect_val(2, 7'h00);
    pulse(dig_up);
    pulse(dig_up);
    expect_val(0, 7'h03);
    pulse(store);
    expect_val(1, 7'h03);
    timeout_en = 1;
    test_start = 1;
    @(posedge clk) #1 test_start = 0;
    `CHK("minutes_left", 7'h03, minutes_left)
    wait_end(66);
    `CHK("timed_len", 1'h1, n > 38)
    repeat (2) @(posedge clk);
    expect_val(3, 7'h00);
    timeout_en = 0;
    test_start = 1;
    @(posedge clk) #1 test_start = 0;
    repeat (100) @(posedge clk);
    expect_val(3, 7'h01);
    manual_stop = 1;
    @(posedge clk) #1 manual_stop = 0;
    wait_end(5);
    repeat (2) @(posedge clk);
    expect_val(3, 7'h00);
    `CHK("engine_on", 1'h0, engine_on)
    give_verdict();
  end
endmodule
`default_nettype wire
